// ### bcc_params.svh
// constants for the bcd calendar counter chain
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
// register indexes; byte address is four times the index
`define BCC_IDX_SEC_U    4'h0
`define BCC_IDX_SEC_T    4'h1
`define BCC_IDX_MIN_U    4'h2
`define BCC_IDX_MIN_T    4'h3
`define BCC_IDX_HR_U     4'h4
`define BCC_IDX_HR_T     4'h5
`define BCC_IDX_DAY_U    4'h6
`define BCC_IDX_DAY_T    4'h7
`define BCC_IDX_MON_U    4'h8
`define BCC_IDX_MON_T    4'h9
`define BCC_IDX_YR_U     4'ha
`define BCC_IDX_YR_T     4'hb
`define BCC_IDX_WDAY     4'hc
`define BCC_IDX_CTRL     4'hd
// hours tens field layout
`define BCC_HT_LOW_BIT   0
`define BCC_HT_MERIDIAN  2
// control register layout and reset
`define BCC_CTRL_FMT24   0
`define BCC_FMT24_RST    1'b1
// calendar limits, two bcd digits; digit and weekday limits one
`define BCC_SEC_LAST     8'h59
`define BCC_MIN_LAST     8'h59
`define BCC_H24_LAST     8'h23
`define BCC_H12_LAST     8'h11
`define BCC_H12_TOP      8'h12
`define BCC_BCD_ZERO     8'h00
`define BCC_BCD_ONE      8'h01
`define BCC_FEB          8'h02
`define BCC_APR          8'h04
`define BCC_JUN          8'h06
`define BCC_SEP          8'h09
`define BCC_NOV          8'h11
`define BCC_DEC          8'h12
`define BCC_DAYS_28      8'h28
`define BCC_DAYS_29      8'h29
`define BCC_DAYS_30      8'h30
`define BCC_DAYS_31      8'h31
`define BCC_YR_LAST      8'h99
`define BCC_DIGIT_LAST   4'h9
`define BCC_WDAY_LAST    4'h6
`define BCC_WDAY_ZERO    4'h0
// axi responses
`define BCC_RESP_OKAY    2'b00
`define BCC_RESP_SLVERR  2'b10
// timing: one tick per second at a 100 ns clock
`define BCC_TICK_NS      1000000000
`define BCC_CLK_NS       100
`endif

// ### bcc_pkg.sv
// types shared by the bcd calendar counter chain
package bcc_pkg;
   // one four-bit bcd digit per field
   typedef struct packed {
      logic [3:0] wday;
      logic [3:0] yr_t;
      logic [3:0] yr_u;
      logic [3:0] mon_t;
      logic [3:0] mon_u;
      logic [3:0] day_t;
      logic [3:0] day_u;
      logic [3:0] hr_t;
      logic [3:0] hr_u;
      logic [3:0] min_t;
      logic [3:0] min_u;
      logic [3:0] sec_t;
      logic [3:0] sec_u;
   } bcc_time_type;
endpackage

// ### bcc_tick_gen.sv
// once-per-second tick divider
`timescale 1ns/1ns
`default_nettype none
module bcc_tick_gen #(
   parameter int CYCLES = 10000000
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output var  logic tick
);
   localparam int CW = $clog2(CYCLES);
   logic [CW-1:0] cnt_reg;

   // count cycles, pulse one cycle when the period is done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (cnt_reg == CW'(CYCLES - 1)) begin
         cnt_reg <= '0;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
         tick    <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### bcc_counter_chain.sv
// bcd calendar counter chain with axi4-lite register access
// Overview of operation
// - every digit is a four-bit positive bcd value, 1001 reads nine
// - each quantity except weekday splits into units and tens registers read separately
// - weekday advances with the day, counting 0 to 6 then 0
// - weekday values carry no fixed day name; host decides mapping
// - hours tens register holds tens bits plus meridian flag, 1 is afternoon
// - in 24-hour format the meridian flag stays zero
// - hours run 12 to 11 per half in 12-hour, 00 to 23 otherwise
// - year digits divisible by four make a leap year allowing February 29
// - year 00 is leap, no century exception
`timescale 1ns/1ns
`default_nettype none
`include "bcc_params.svh"
module bcc_counter_chain #(
   parameter int TICK_CYCLES = `BCC_TICK_NS / `BCC_CLK_NS,
   parameter int ADDR_W      = 6
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready
);
   bcc_pkg::bcc_time_type time_reg;
   bcc_pkg::bcc_time_type time_tick;
   bcc_pkg::bcc_time_type time_next;
   logic              fmt24_reg;
   logic              fmt24_next;
   logic              tick;
   logic              aw_hold_reg;
   logic              w_hold_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [3:0]        w_data_reg;
   logic              w_lane0_reg;
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic              wr_fire;
   logic [3:0]        wr_idx;
   logic              day_adv;
   logic              leap;

   // two bcd digits plus one, units wrapping into tens
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == `BCC_DIGIT_LAST) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction

   // a two-digit year divides by four when odd tens meet 2 or 6, even tens 0, 4 or 8
   function automatic logic is_leap(input logic [3:0] t, input logic [3:0] u);
      if (t[0]) begin
         return (u == 4'h2) || (u == 4'h6);
      end
      return (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
   endfunction

   // last day of a month in bcd
   function automatic logic [7:0] last_day(input logic [7:0] mon, input logic lp);
      if (mon == `BCC_FEB) begin
         return lp ? `BCC_DAYS_29 : `BCC_DAYS_28;
      end
      if (mon == `BCC_APR || mon == `BCC_JUN || mon == `BCC_SEP || mon == `BCC_NOV) begin
         return `BCC_DAYS_30;
      end
      return `BCC_DAYS_31;
   endfunction

   // word address to register index; misaligned or unmapped gives an error
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(`BCC_IDX_CTRL));
   endfunction

   bcc_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   assign leap    = is_leap(time_reg.yr_t, time_reg.yr_u);
   assign aw_take = awvalid && awready;
   assign w_take  = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid;
   assign wr_idx  = aw_addr_reg[5:2];

   // carry chain, one step per tick; the whole chain settles in one cycle
   always_comb begin
      logic [7:0] hv;
      logic       cm;
      logic       ch;
      hv       = {2'b00, time_reg.hr_t[1:0], time_reg.hr_u};
      cm       = 1'b0;
      ch       = 1'b0;
      day_adv  = 1'b0;
      time_tick = time_reg;
      if (tick) begin
         // seconds, then minutes
         if ({time_reg.sec_t, time_reg.sec_u} == `BCC_SEC_LAST) begin
            {time_tick.sec_t, time_tick.sec_u} = `BCC_BCD_ZERO;
            cm = 1'b1;
         end else begin
            {time_tick.sec_t, time_tick.sec_u} = bcd_inc({time_reg.sec_t, time_reg.sec_u});
         end
         if (cm) begin
            if ({time_reg.min_t, time_reg.min_u} == `BCC_MIN_LAST) begin
               {time_tick.min_t, time_tick.min_u} = `BCC_BCD_ZERO;
               ch = 1'b1;
            end else begin
               {time_tick.min_t, time_tick.min_u} = bcd_inc({time_reg.min_t, time_reg.min_u});
            end
         end
         // hours in either format
         if (ch) begin
            if (fmt24_reg) begin
               if (hv == `BCC_H24_LAST) begin
                  hv      = `BCC_BCD_ZERO;
                  day_adv = 1'b1;
               end else begin
                  hv = bcd_inc(hv);
               end
            end else if (hv == `BCC_H12_LAST) begin
               hv = `BCC_H12_TOP;
               time_tick.hr_t[`BCC_HT_MERIDIAN] = !time_reg.hr_t[`BCC_HT_MERIDIAN];
               day_adv = time_reg.hr_t[`BCC_HT_MERIDIAN]; // pm to am only
            end else if (hv == `BCC_H12_TOP) begin
               hv = `BCC_BCD_ONE;
            end else begin
               hv = bcd_inc(hv);
            end
            time_tick.hr_u       = hv[3:0];
            time_tick.hr_t[1:0]  = hv[5:4];
         end
         // weekday and day of month
         if (day_adv) begin
            time_tick.wday = (time_reg.wday == `BCC_WDAY_LAST) ? `BCC_WDAY_ZERO
                                                               : time_reg.wday + 4'h1;
            if ({time_reg.day_t, time_reg.day_u} ==
                last_day({time_reg.mon_t, time_reg.mon_u}, leap)) begin
               {time_tick.day_t, time_tick.day_u} = `BCC_BCD_ONE;
               if ({time_reg.mon_t, time_reg.mon_u} == `BCC_DEC) begin
                  {time_tick.mon_t, time_tick.mon_u} = `BCC_BCD_ONE;
                  {time_tick.yr_t, time_tick.yr_u} =
                     ({time_reg.yr_t, time_reg.yr_u} == `BCC_YR_LAST) ? `BCC_BCD_ZERO
                     : bcd_inc({time_reg.yr_t, time_reg.yr_u});
               end else begin
                  {time_tick.mon_t, time_tick.mon_u} = bcd_inc({time_reg.mon_t, time_reg.mon_u});
               end
            end else begin
               {time_tick.day_t, time_tick.day_u} = bcd_inc({time_reg.day_t, time_reg.day_u});
            end
         end
      end
   end

   // a host write overrides the tick result for the digit it hits
   always_comb begin
      time_next  = time_tick;
      fmt24_next = fmt24_reg;
      if (wr_fire && w_lane0_reg && addr_ok(aw_addr_reg)) begin // address checked here, beats in either order
         unique case (wr_idx)
            `BCC_IDX_SEC_U: time_next.sec_u = w_data_reg;
            `BCC_IDX_SEC_T: time_next.sec_t = w_data_reg;
            `BCC_IDX_MIN_U: time_next.min_u = w_data_reg;
            `BCC_IDX_MIN_T: time_next.min_t = w_data_reg;
            `BCC_IDX_HR_U:  time_next.hr_u  = w_data_reg;
            `BCC_IDX_HR_T:  time_next.hr_t  = w_data_reg;
            `BCC_IDX_DAY_U: time_next.day_u = w_data_reg;
            `BCC_IDX_DAY_T: time_next.day_t = w_data_reg;
            `BCC_IDX_MON_U: time_next.mon_u = w_data_reg;
            `BCC_IDX_MON_T: time_next.mon_t = w_data_reg;
            `BCC_IDX_YR_U:  time_next.yr_u  = w_data_reg;
            `BCC_IDX_YR_T:  time_next.yr_t  = w_data_reg;
            `BCC_IDX_WDAY:  time_next.wday  = w_data_reg; // plain count, no day names
            `BCC_IDX_CTRL:  fmt24_next      = w_data_reg[`BCC_CTRL_FMT24];
            default: ;
         endcase
      end
      // the new format applies in the same cycle, so no pm bit survives a switch
      if (fmt24_next) begin
         time_next.hr_t[`BCC_HT_MERIDIAN] = 1'b0;
      end
   end

   // time digits; host must not load impossible values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_reg   <= '0;
         time_reg.day_u <= 4'h1;
         time_reg.mon_u <= 4'h1;
      end else begin
         time_reg <= time_next;
      end
   end

   // format selection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt24_reg <= `BCC_FMT24_RST;
      end else begin
         fmt24_reg <= fmt24_next;
      end
   end

   // write address and data taken in either order, then one response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= 4'h0;
         w_lane0_reg <= 1'b0;
         awready     <= 1'b0;
         wready      <= 1'b0;
         bvalid      <= 1'b0;
         bresp       <= `BCC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_take) begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= wdata[3:0];
            w_lane0_reg <= wstrb[0]; // no address test yet: data may arrive ahead of it
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
         awready <= !(aw_hold_reg || aw_take) && !bvalid;
         wready  <= !(w_hold_reg || w_take) && !bvalid;
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= addr_ok(aw_addr_reg) ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // reads: four-bit digits in the low bits, upper bits zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `BCC_RESP_OKAY;
      end else begin
         arready <= !ar_take && !rvalid;
         if (ar_take) begin
            rvalid <= 1'b1;
            rresp  <= addr_ok(araddr) ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
            unique case (araddr[5:2])
               `BCC_IDX_SEC_U: rdata <= {28'h0, time_reg.sec_u};
               `BCC_IDX_SEC_T: rdata <= {28'h0, time_reg.sec_t};
               `BCC_IDX_MIN_U: rdata <= {28'h0, time_reg.min_u};
               `BCC_IDX_MIN_T: rdata <= {28'h0, time_reg.min_t};
               `BCC_IDX_HR_U:  rdata <= {28'h0, time_reg.hr_u};
               `BCC_IDX_HR_T:  rdata <= {28'h0, time_reg.hr_t};
               `BCC_IDX_DAY_U: rdata <= {28'h0, time_reg.day_u};
               `BCC_IDX_DAY_T: rdata <= {28'h0, time_reg.day_t};
               `BCC_IDX_MON_U: rdata <= {28'h0, time_reg.mon_u};
               `BCC_IDX_MON_T: rdata <= {28'h0, time_reg.mon_t};
               `BCC_IDX_YR_U:  rdata <= {28'h0, time_reg.yr_u};
               `BCC_IDX_YR_T:  rdata <= {28'h0, time_reg.yr_t};
               `BCC_IDX_WDAY:  rdata <= {28'h0, time_reg.wday};
               `BCC_IDX_CTRL:  rdata <= {31'h0, fmt24_reg};
               default:        rdata <= '0;
            endcase
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // checks on the counting behaviour
   chk_sec_bcd: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(tick) && !$past(wr_fire) && $past(time_reg.sec_u) == 4'h9 |->
         time_reg.sec_u == 4'h0)
      else $error("seconds units did not wrap after nine");

   chk_weekday_step: assert property (@(posedge aclk) disable iff (!aresetn)
      day_adv && !wr_fire |=>
         time_reg.wday == (($past(time_reg.wday) == 4'h6) ? 4'h0 : $past(time_reg.wday) + 4'h1))
      else $error("weekday did not step with the day");

   chk_meridian_24h: assert property (@(posedge aclk) disable iff (!aresetn)
      fmt24_reg |-> !time_reg.hr_t[2])
      else $error("meridian set in 24-hour format");

   chk_hour_24_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && fmt24_reg && !wr_fire && {time_reg.hr_t[1:0], time_reg.hr_u} == 6'h23 &&
      {time_reg.min_t, time_reg.min_u, time_reg.sec_t, time_reg.sec_u} == 16'h5959 |=>
         time_reg.hr_t == 4'h0 && time_reg.hr_u == 4'h0)
      else $error("hour did not wrap 23 to 00");

   chk_feb_leap: assert property (@(posedge aclk) disable iff (!aresetn)
      day_adv && !wr_fire && {time_reg.mon_t, time_reg.mon_u} == 8'h02 &&
      {time_reg.day_t, time_reg.day_u} == 8'h28 |=>
         {time_reg.day_t, time_reg.day_u} == ($past(leap) ? 8'h29 : 8'h01))
      else $error("february end ignores leap year");

   chk_year_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      {time_reg.yr_t, time_reg.yr_u} == 8'h00 |-> leap)
      else $error("year 00 not leap");

   chk_min_carry: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !wr_fire && {time_reg.sec_t, time_reg.sec_u} == 8'h59 &&
      {time_reg.min_t, time_reg.min_u} != 8'h59 |=>
         {time_reg.min_t, time_reg.min_u} == bcd_inc($past({time_reg.min_t, time_reg.min_u})))
      else $error("minutes missed the seconds carry");

   chk_meridian_flip: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !fmt24_reg && !wr_fire && {time_reg.hr_t[0], time_reg.hr_u} == 5'h11 &&
      {time_reg.min_t, time_reg.min_u, time_reg.sec_t, time_reg.sec_u} == 16'h5959 |=>
         time_reg.hr_t[2] != $past(time_reg.hr_t[2]) && time_reg.hr_u == 4'h2 &&
         (time_reg.wday != $past(time_reg.wday)) == $past(time_reg.hr_t[2]))
      else $error("12-hour rollover wrong");
endmodule
`default_nettype wire

// ### bcc_host_model.sv
// host cpu model: axi4-lite master for the register port
`timescale 1ns/1ns
`default_nettype none
module bcc_host_model (
   input  wire logic        aclk,
   output var  logic [5:0]  awaddr,
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   output var  logic        wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output var  logic        bready,
   output var  logic [5:0]  araddr,
   output var  logic        arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output var  logic        rready
);
   // bus idle from time zero
   initial begin
      awaddr = 6'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 6'h00;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // one write; released payload is inverted so stale values never match
   task automatic write_reg(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   // one read; rready held from the start until rvalid is seen
   task automatic read_reg(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the bcd calendar counter chain
`timescale 1ns/1ns
`default_nettype none
`include "bcc_params.svh"
module tb;
   localparam int TICKS = 200;
   typedef struct {int s; int m; int h; int pm; int d; int mo; int y; int w; int f24;} bcc_tb_clk_type;
   logic        aclk;
   logic        aresetn;
   logic [5:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          mismatches = 0;
   int          total_checks = 0;
   int          seed = 40;
   int          case_no = 0;

   bcc_counter_chain #(.TICK_CYCLES(TICKS), .ADDR_W(6)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   bcc_host_model u_host (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial aclk = 1'b0;
   always #50 aclk = ~aclk;

   function automatic int rnd(input int n);
      return ($random(seed) & 32'h7fffffff) % n;
   endfunction

   function automatic int mdays(input int mo, input int y);
      if (mo == 2) return (y % 4 == 0) ? 29 : 28;
      if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
      return 31;
   endfunction

   // reference one-second step with all carries
   function automatic bcc_tb_clk_type advance(input bcc_tb_clk_type t);
      logic day;
      day = 1'b0;
      t.s = (t.s + 1) % 60;
      if (t.s == 0) t.m = (t.m + 1) % 60;
      if (t.s == 0 && t.m == 0) begin
         if (t.f24 != 0) begin
            t.h = (t.h + 1) % 24;
            day = (t.h == 0);
         end else begin
            day = (t.h == 11 && t.pm == 1);
            if (t.h == 11) t.pm = 1 - t.pm;
            t.h = t.h % 12 + 1;
         end
      end
      if (day) begin
         t.w = (t.w + 1) % 7;
         t.d = (t.d == mdays(t.mo, t.y)) ? 1 : t.d + 1;
         if (t.d == 1) t.mo = t.mo % 12 + 1;
         if (t.d == 1 && t.mo == 1) t.y = (t.y + 1) % 100;
      end
      return t;
   endfunction

   // digit i of the packed struct sits at bits 4i+3:4i, same as register index
   function automatic bcc_pkg::bcc_time_type pack(input bcc_tb_clk_type t);
      bcc_pkg::bcc_time_type p;
      p.sec_u = 4'(t.s % 10);
      p.sec_t = 4'(t.s / 10);
      p.min_u = 4'(t.m % 10);
      p.min_t = 4'(t.m / 10);
      p.hr_u = 4'(t.h % 10);
      p.hr_t = 4'(t.h / 10 + 4 * t.pm);
      p.day_u = 4'(t.d % 10);
      p.day_t = 4'(t.d / 10);
      p.mon_u = 4'(t.mo % 10);
      p.mon_t = 4'(t.mo / 10);
      p.yr_u = 4'(t.y % 10);
      p.yr_t = 4'(t.y / 10);
      p.wday = 4'(t.w);
      return p;
   endfunction

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input int i, input logic [31:0] v);
      logic [1:0] r;
      u_host.write_reg(6'(4 * i), v, 4'hf, r);
      check_resp(r, `BCC_RESP_OKAY);
   endtask

   task automatic rd(input int i, output logic [31:0] d);
      logic [1:0] r;
      u_host.read_reg(6'(4 * i), d, r);
      check_resp(r, `BCC_RESP_OKAY);
   endtask

   // poll seconds units until it moves; bounded so a dead tick shows up
   task automatic wait_change(input logic [3:0] old);
      logic [31:0] d;
      int n;
      n = 0;
      d = {28'h0, old};
      while (d[3:0] === old && n < 100) begin
         rd(0, d);
         n++;
      end
      check_val(32'(n < 100), 32'h1);
   endtask

   // load a full time just after a tick, then check it one tick later
   task automatic run_case(input bcc_tb_clk_type t);
      logic [51:0] v;
      logic [51:0] e;
      logic [31:0] d;
      v = pack(t);
      e = pack(advance(t));
      rd(0, d);
      wait_change(d[3:0]);
      wr(13, 32'(t.f24));
      for (int i = 0; i < 13; i++) wr(i, {28'h0, v[4*i +: 4]});
      wait_change(v[3:0]);
      for (int i = 0; i < 13; i++) begin
         rd(i, d);
         check_val(d, {28'h0, e[4*i +: 4]});
      end
      case_no++;
      $display("case %0d done", case_no);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog: about four times the expected run
   initial begin
      #3000000;
      mismatches++;
      end_sim();
   end

   initial begin
      bcc_tb_clk_type cs [9];
      bcc_tb_clk_type t;
      logic [51:0] v;
      logic [31:0] d;
      logic [1:0] r;
      // hand-picked carries; last one leaves 12 pm for the format switch
      cs = '{'{9, 0, 0, 0, 1, 1, 0, 0, 1}, '{59, 59, 23, 0, 31, 12, 99, 6, 1},
             '{59, 59, 23, 0, 28, 2, 0, 2, 1}, '{59, 59, 23, 0, 28, 2, 1, 3, 1},
             '{59, 59, 23, 0, 29, 2, 4, 5, 1}, '{59, 59, 23, 0, 30, 4, 10, 0, 1},
             '{59, 59, 12, 0, 31, 1, 20, 1, 0}, '{59, 59, 11, 1, 31, 3, 30, 4, 0},
             '{59, 59, 11, 0, 30, 6, 30, 4, 0}};
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      v = pack(bcc_tb_clk_type'{0, 0, 0, 0, 1, 1, 0, 0, 1});
      for (int i = 0; i < 13; i++) begin
         rd(i, d);
         check_val(d, {28'h0, v[4*i +: 4]});
      end
      rd(13, d);
      check_val(d, 32'h1);
      // refused accesses, then a write without strobes that is accepted and changes nothing
      u_host.read_reg(6'h38, d, r);
      check_resp(r, `BCC_RESP_SLVERR);
      check_val(d, 32'h0);
      u_host.read_reg(6'h02, d, r);
      check_resp(r, `BCC_RESP_SLVERR);
      u_host.write_reg(6'h38, 32'h1, 4'hf, r);
      check_resp(r, `BCC_RESP_SLVERR);
      u_host.write_reg(6'h31, 32'h3, 4'hf, r);
      check_resp(r, `BCC_RESP_SLVERR);
      u_host.write_reg(6'h30, 32'h5, 4'h0, r);
      check_resp(r, `BCC_RESP_OKAY);
      rd(12, d);
      check_val(d, 32'h0);
      $display("case refusals done");
      foreach (cs[k]) run_case(cs[k]);
      wr(13, 32'h1);
      rd(5, d);
      check_val(d, 32'h1);
      // random valid settings, biased toward carries
      for (int k = 0; k < 8; k++) begin
         t.f24 = rnd(2);
         t.pm = (t.f24 != 0) ? 0 : rnd(2);
         t.h = (t.f24 != 0) ? rnd(24) : rnd(12) + 1;
         t.s = rnd(2) ? 59 : rnd(60);
         t.m = rnd(2) ? 59 : rnd(60);
         t.mo = rnd(12) + 1;
         t.y = rnd(100);
         t.w = rnd(7);
         t.d = rnd(2) ? mdays(t.mo, t.y) : rnd(28) + 1;
         run_case(t);
      end
      end_sim();
   end
endmodule
`default_nettype wire
